// File: logic/lfs_pkg.sv
// Package for the LIN frame status and sync measurement block.
// Holds register layouts, reset values, event carriers and the sync tick window.
// Assumes one core clock and a frame engine that supplies one-cycle event pulses.
package lfs_pkg;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam logic [15:0] LFS_SYNC_PERIOD_ADDR = 16'h2084;  // Read-only sync period register.
  localparam logic [7:0]  LFS_SYNC_PERIOD_RST  = 8'h00;
  localparam logic [7:0]  LFS_STATUS_RST       = 8'h00;
  localparam logic [3:0]  LFS_CMD_RST          = 4'h0;

  // Command bit positions.
  localparam int LFS_CMD_TX_HEADER   = 0;
  localparam int LFS_CMD_TX_RESPONSE = 1;
  localparam int LFS_CMD_RX_HEADER   = 2;
  localparam int LFS_CMD_RX_RESPONSE = 3;

  // ------------------------------------------------------------------
  // Sync field timing in baud ticks
  // ------------------------------------------------------------------
  localparam int          LFS_BITS_PER_SYNC   = 8;
  localparam int          LFS_TICKS_PER_BIT   = 16;
  localparam logic [7:0]  LFS_SYNC_NOMINAL    = 8'(LFS_BITS_PER_SYNC * LFS_TICKS_PER_BIT);
  localparam logic [7:0]  LFS_SYNC_MIN        = 8'h006A;  // 106 ticks.
  localparam logic [7:0]  LFS_SYNC_MAX        = 8'h0098;  // 152 ticks.
  localparam logic [7:0]  LFS_FIRST_BYTE_NULL = 8'h0000;

  // Status register layout, bit 7 first.
  typedef struct packed {
    logic delim_fault;
    logic break_fault;
    logic rx_done;
    logic tx_done;
    logic rx_busy;
    logic tx_busy;
    logic first_byte_framing_flag;
    logic response_phase;
  } lfs_status_t;

  // Event pulses and levels from the frame engine.
  typedef struct packed {
    logic       baud_tick;    // One pulse per sixteenth of a bit.
    logic       sync_fall;    // Falling edge that starts the sync field.
    logic       sync_end;     // Last falling edge that closes the sync field.
    logic       hdr_start;    // Header transfer begins.
    logic       hdr_done;     // Header finished without error.
    logic       resp_start;   // Response transfer begins.
    logic       resp_done;    // Response finished without error.
    logic       error;        // Any frame error that aborts the frame.
    logic       in_break;     // Level: master is sending the break field.
    logic       in_delim;     // Level: master is sending the break delimiter.
    logic       line_rx;      // Level: bus read back.
    logic       byte_valid;   // Received response byte with its stop bit.
    logic [7:0] byte_data;
    logic       byte_stop;
  } lfs_evt_t;

endpackage : lfs_pkg

// File: logic/lfs_frame_status.sv
// Status, command and sync-period measurement logic of a LIN frame engine.
// Assumes all inputs are synchronous to clock and event pulse fields are one-cycle pulses; in_break, in_delim and line_rx are levels.
//
// Overview of operation
// - Count baud ticks across the sync field into an 8-bit read-only value.
// - Accept a sync period only from 106 to 152 ticks inclusive.
// - Master header: low readback in delimiter sets delimiter fault, cleared at command end.
// - Master header: high readback in break sets break fault, cleared at command end.
// - Set receive done after sequences ending in response reception; clear on new command.
// - Set transmit done after sequences ending in a transmission; clear on new command.
// - Receiver active from header or response receive start until command end or error.
// - Transmitter active from header or response send start until command end or error.
// - After receive header, first byte 0x00 with low stop sets first-byte flag.
// - Clear first-byte flag at the falling edge starting the sync field.
// - First-byte flag never aborts the frame; software interprets it.
// - Phase bit low during header, high during response.
// - Sync out of window sets sync error, aborts frame, clears commands.
// - Software writes ones to start commands; hardware clears them on completion.
`timescale 1ns/1ps
module lfs_frame_status
  import lfs_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire lfs_evt_t    evt,
  input  wire logic        cmd_wr,
  input  wire logic [3:0]  cmd_wdata,
  output logic [3:0]       cmd_reg,
  output logic [CNT_W-1:0] sync_period_measure,
  output lfs_status_t      frame_engine_status,
  output logic             sync_error
);

  // ------------------------------------------------------------------
  // Elaboration check
  // ------------------------------------------------------------------
  if (CNT_W != 8) begin : g_bad_width
    $error("lfs_frame_status: the sync counter must be 8 bits wide");
  end

  // Saturating increment keeps an overlong field from wrapping into the window.
  function automatic logic [7:0] lfs_sat_inc(input logic [7:0] v, input logic en);
    lfs_sat_inc = (en && v != 8'h00FF) ? v + 8'h0001 : v;
  endfunction : lfs_sat_inc

  // ------------------------------------------------------------------
  // Sequence decode
  // ------------------------------------------------------------------
  logic       meas_reg;
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic       sync_bad;
  logic       hdr_only;
  logic       seq_done;
  logic       abort;
  logic       cmd_end;
  logic       new_cmd;
  logic       first_pend_reg;

  assign cnt_next = lfs_sat_inc(cnt_reg, evt.baud_tick);
  assign sync_bad = meas_reg && ((evt.sync_end && (cnt_next < LFS_SYNC_MIN || cnt_next > LFS_SYNC_MAX)) ||
                                 (!evt.sync_end && cnt_next > LFS_SYNC_MAX));
  assign hdr_only = evt.hdr_done && !cmd_reg[LFS_CMD_TX_RESPONSE] && !cmd_reg[LFS_CMD_RX_RESPONSE];
  assign seq_done = hdr_only || evt.resp_done;
  assign abort    = evt.error || sync_bad;
  assign cmd_end  = seq_done || abort;
  assign new_cmd  = cmd_wr && (cmd_wdata != LFS_CMD_RST);

  // ------------------------------------------------------------------
  // Sync measurement
  // ------------------------------------------------------------------
  // tick counting
  always_ff @(posedge clock) begin
    if (rst) begin
      meas_reg <= 1'b0;
      cnt_reg  <= 8'h0000;
    end else if (evt.sync_fall) begin
      meas_reg <= 1'b1;
      cnt_reg  <= 8'h0000;
    end else if (meas_reg) begin
      cnt_reg  <= cnt_next;
      meas_reg <= !(evt.sync_end || sync_bad);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      sync_period_measure <= LFS_SYNC_PERIOD_RST;
    end else if (meas_reg && (evt.sync_end || sync_bad)) begin
      sync_period_measure <= cnt_next;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      sync_error <= 1'b0;
    end else begin
      sync_error <= sync_bad;
    end
  end

  // ------------------------------------------------------------------
  // Command bits
  // ------------------------------------------------------------------
  // set by software, cleared by hardware; a fresh write wins over the clear.
  always_ff @(posedge clock) begin
    if (rst) begin
      cmd_reg <= LFS_CMD_RST;
    end else begin
      cmd_reg <= (cmd_reg & ~(abort ? 4'hF :
                              {evt.resp_done, evt.hdr_done, evt.resp_done, evt.hdr_done}))
                 | (cmd_wr ? cmd_wdata : 4'h0);
    end
  end

  // ------------------------------------------------------------------
  // Fault bits of a master header
  // ------------------------------------------------------------------
  logic brk_set;
  logic dlm_set;
  assign brk_set = cmd_reg[LFS_CMD_TX_HEADER] && frame_engine_status.tx_busy && evt.in_break && evt.line_rx;
  assign dlm_set = cmd_reg[LFS_CMD_TX_HEADER] && frame_engine_status.tx_busy && evt.in_delim && !evt.line_rx;

  always_ff @(posedge clock) begin
    if (rst) begin
      frame_engine_status.break_fault <= 1'b0;
      frame_engine_status.delim_fault <= 1'b0;
    end else begin
      frame_engine_status.break_fault <= brk_set || (frame_engine_status.break_fault && !cmd_end);
      frame_engine_status.delim_fault <= dlm_set || (frame_engine_status.delim_fault && !cmd_end);
    end
  end

  // ------------------------------------------------------------------
  // Done bits
  // ------------------------------------------------------------------
  logic rxd_set;
  logic txd_set;
  assign rxd_set = evt.resp_done && cmd_reg[LFS_CMD_RX_RESPONSE];
  assign txd_set = (hdr_only && cmd_reg[LFS_CMD_TX_HEADER]) || (evt.resp_done && cmd_reg[LFS_CMD_TX_RESPONSE]);

  // a new command clears, but a completion in the same cycle wins.
  always_ff @(posedge clock) begin
    if (rst) begin
      frame_engine_status.rx_done <= 1'b0;
      frame_engine_status.tx_done <= 1'b0;
    end else begin
      frame_engine_status.rx_done <= rxd_set || (frame_engine_status.rx_done && !new_cmd);
      frame_engine_status.tx_done <= txd_set || (frame_engine_status.tx_done && !new_cmd);
    end
  end

  // ------------------------------------------------------------------
  // Busy and phase
  // ------------------------------------------------------------------
  logic rxb_set;
  logic txb_set;
  assign rxb_set = (evt.hdr_start && cmd_reg[LFS_CMD_RX_HEADER]) || (evt.resp_start && cmd_reg[LFS_CMD_RX_RESPONSE]);
  assign txb_set = (evt.hdr_start && cmd_reg[LFS_CMD_TX_HEADER]) || (evt.resp_start && cmd_reg[LFS_CMD_TX_RESPONSE]);

  always_ff @(posedge clock) begin
    if (rst) begin
      frame_engine_status.rx_busy <= 1'b0;
      frame_engine_status.tx_busy <= 1'b0;
    end else begin
      frame_engine_status.rx_busy <= rxb_set || (frame_engine_status.rx_busy && !cmd_end);
      frame_engine_status.tx_busy <= txb_set || (frame_engine_status.tx_busy && !cmd_end);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      frame_engine_status.response_phase <= 1'b0;
    end else if (evt.resp_start) begin
      frame_engine_status.response_phase <= 1'b1;
    end else if (evt.hdr_start || evt.resp_done || abort) begin
      frame_engine_status.response_phase <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // First response byte after a received header
  // ------------------------------------------------------------------
  logic fb_set;
  assign fb_set = first_pend_reg && evt.byte_valid && evt.byte_data == LFS_FIRST_BYTE_NULL && !evt.byte_stop;

  // The pending mark arms only after a receive-header command finishes its header.
  always_ff @(posedge clock) begin
    if (rst) begin
      first_pend_reg <= 1'b0;
    end else if (evt.hdr_done && cmd_reg[LFS_CMD_RX_HEADER]) begin
      first_pend_reg <= 1'b1;
    end else if (evt.byte_valid || abort || evt.sync_fall) begin
      first_pend_reg <= 1'b0;
    end
  end

  // cleared at sync start; set wins.
  always_ff @(posedge clock) begin
    if (rst) begin
      frame_engine_status.first_byte_framing_flag <= 1'b0;
    end else begin
      frame_engine_status.first_byte_framing_flag <= fb_set ||
        (frame_engine_status.first_byte_framing_flag && !evt.sync_fall);
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  chk_sync_latch: assert property (meas_reg && evt.sync_end |=> sync_period_measure == $past(cnt_next))
    else $error("sync period not latched at field end");
  chk_window_ok: assert property (meas_reg && evt.sync_end && cnt_next >= 8'h006A && cnt_next <= 8'h0098
                                  |=> !sync_error)
    else $error("in-window sync flagged as error");
  chk_overrun_abort: assert property (meas_reg && !evt.sync_end && cnt_reg == 8'h0098 && evt.baud_tick && !cmd_wr
                                      |=> sync_error && cmd_reg == 4'h0)
    else $error("sync overrun did not abort");
  chk_delim_fault: assert property (dlm_set |=> frame_engine_status.delim_fault)
    else $error("delimiter fault missed");
  chk_break_clear: assert property (frame_engine_status.break_fault && cmd_end && !brk_set
                                    |=> !frame_engine_status.break_fault)
    else $error("break fault not cleared at command end");
  chk_rx_done: assert property (evt.resp_done && cmd_reg[3] |=> frame_engine_status.rx_done)
    else $error("receive done not set");
  chk_tx_done: assert property (hdr_only && cmd_reg == 4'h1 |=> frame_engine_status.tx_done && cmd_reg[0] == $past(cmd_wr && cmd_wdata[0]))
    else $error("header-only send not completed");
  chk_busy_drop: assert property (cmd_end && !rxb_set && !txb_set
                                  |=> !frame_engine_status.rx_busy && !frame_engine_status.tx_busy)
    else $error("busy not dropped at command end");
  chk_first_clear: assert property (evt.sync_fall && !fb_set |=> !frame_engine_status.first_byte_framing_flag)
    else $error("first-byte flag survived sync start");
  chk_phase_resp: assert property (evt.resp_start |=> frame_engine_status.response_phase
                                   ##1 (frame_engine_status.response_phase || $past(evt.resp_done || abort || evt.hdr_start)))
    else $error("response phase not shown");
  chk_period_hold: assert property (!(meas_reg && (evt.sync_end || sync_bad)) |=> $stable(sync_period_measure))
    else $error("sync period changed outside a field end");

  cov_good_sync: cover property (meas_reg && evt.sync_end && !sync_bad);
  cov_sync_error: cover property (sync_bad);
  cov_no_response: cover property (fb_set);

endmodule : lfs_frame_status

// File: verif/lfs_bus_node.sv
// Far-side node and frame engine event source for the status block.
// Assumes the bench calls its tasks just after a falling clock edge.
`timescale 1ns/1ps
module lfs_bus_node
  import lfs_pkg::*;
(
  input  wire logic clock,
  output lfs_evt_t  evt
);
  // ----------------------------------------------------------------
  // Event sequencing
  // ----------------------------------------------------------------
  // The idle bus is recessive, so the read-back line rests high.
  initial begin
    evt = '0;
    evt.line_rx = 1'b1;
  end

  // Pulse select: 0 hdr start, 1 hdr done, 2 resp start, 3 resp done, 4 error, 5 sync fall.
  task set_evt(input int sel, input logic v);
    case (sel)
      0: evt.hdr_start = v;
      1: evt.hdr_done = v;
      2: evt.resp_start = v;
      3: evt.resp_done = v;
      4: evt.error = v;
      default: evt.sync_fall = v;
    endcase
  endtask : set_evt

  task pulse(input int sel);
    set_evt(sel, 1'b1);
    @(negedge clock);
    set_evt(sel, 1'b0);
  endtask : pulse

  task levels(input logic brk, input logic dlm, input logic rx);
    evt.in_break = brk;
    evt.in_delim = dlm;
    evt.line_rx = rx;
  endtask : levels

  // Byte fields are inverted once stale, so nothing leans on a leftover value.
  task rx_byte(input logic [7:0] d, input logic s);
    evt.byte_valid = 1'b1;
    evt.byte_data = d;
    evt.byte_stop = s;
    @(negedge clock);
    evt.byte_valid = 1'b0;
    evt.byte_data = ~d;
    evt.byte_stop = ~s;
  endtask : rx_byte

  // Sync field of n ticks; the closing edge rides on the last tick.
  task sync_field(input int n);
    pulse(5);
    for (int i = 0; i < n; i++) begin
      evt.baud_tick = 1'b1;
      evt.sync_end = (i == n - 1);
      @(negedge clock);
    end
    evt.baud_tick = 1'b0;
    evt.sync_end = 1'b0;
  endtask : sync_field
endmodule : lfs_bus_node

// File: verif/test_lfs_frame_status.sv
// Self-checking bench for the frame status and sync measurement block.
// Assumes inputs change at the falling edge and outputs settle one clock later.
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module test_lfs_frame_status
  import lfs_pkg::*;
;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        cmd_wr = 1'b0;
  logic [3:0]  cmd_wdata = 4'h0;
  logic [3:0]  cmd_reg;
  logic [7:0]  sync_period_measure;
  lfs_status_t frame_engine_status;
  logic        sync_error;
  lfs_evt_t    evt;
  int          errors = 0;
  int          checked = 0;
  int          err_pulses = 0;
  int          sync_len [5] = '{128, 106, 152, 105, 154};

  always #10 clock = ~clock;

  lfs_bus_node nd (
    .clock (clock),
    .evt   (evt)
  );

  lfs_frame_status dut_u (
    .clock               (clock),
    .rst                 (rst),
    .evt                 (evt),
    .cmd_wr              (cmd_wr),
    .cmd_wdata           (cmd_wdata),
    .cmd_reg             (cmd_reg),
    .sync_period_measure (sync_period_measure),
    .frame_engine_status (frame_engine_status),
    .sync_error          (sync_error)
  );

  // Counts sync error pulses at the falling edge, where the registered output has settled.
  // An overrun pulses in mid-field, one clock before the bench looks, so a plain sample would miss it.
  always @(negedge clock) begin
    if (sync_error === 1'b1) begin
      err_pulses++;
    end
  end

  // ----------------------------------------------------------------
  // Shared drivers
  // ----------------------------------------------------------------
  task wcmd(input logic [3:0] v);
    cmd_wr = 1'b1;
    cmd_wdata = v;
    @(negedge clock);
    cmd_wr = 1'b0;
  endtask : wcmd

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Window edges, one short field and one overrun; a bad field must also drop the pending command.
  // An overrun stops the count one tick past the window, so the held period is that count.
  task test_sync;
    logic err;
    logic over;
    int   seen;
    foreach (sync_len[i]) begin
      err  = (sync_len[i] < 106) || (sync_len[i] > 152);
      over = sync_len[i] > 152;
      seen = err_pulses;
      wcmd(4'h4);
      nd.sync_field(sync_len[i]);
      `CHK(sync_period_measure, over ? LFS_SYNC_MAX + 8'h01 : 8'(sync_len[i]))
      `CHK(sync_error, err && !over)
      @(negedge clock);
      `CHK(cmd_reg, err ? 4'h0 : 4'h4)
      `CHK(err_pulses - seen, int'(err))
      `CHK(sync_period_measure, over ? LFS_SYNC_MAX + 8'h01 : 8'(sync_len[i]))
    end
    $display("test sync done");
  endtask : test_sync

  // Master header with a break read-back fault and a delimiter fault.
  task test_tx_header;
    wcmd(4'h1);
    nd.pulse(0);
    `CHK(frame_engine_status, 8'h04)
    nd.levels(1'b1, 1'b0, 1'b1);
    @(negedge clock);
    nd.levels(1'b0, 1'b1, 1'b0);
    `CHK(frame_engine_status, 8'h44)
    @(negedge clock);
    nd.levels(1'b0, 1'b0, 1'b1);
    `CHK(frame_engine_status, 8'hC4)
    nd.pulse(1);
    `CHK(frame_engine_status, 8'h10)
    `CHK(cmd_reg, 4'h0)
    $display("test tx header done");
  endtask : test_tx_header

  // Slave receive with an empty first byte, which must not stop the frame.
  task test_rx_frame;
    wcmd(4'hC);
    `CHK(frame_engine_status, 8'h00)
    nd.pulse(0);
    `CHK(frame_engine_status, 8'h08)
    nd.pulse(1);
    `CHK(cmd_reg, 4'h8)
    nd.rx_byte(8'h00, 1'b0);
    nd.pulse(2);
    `CHK(frame_engine_status, 8'h0B)
    `CHK(cmd_reg, 4'h8)
    nd.pulse(3);
    `CHK(frame_engine_status, 8'h22)
    nd.pulse(5);
    `CHK(frame_engine_status, 8'h20)
    wcmd(4'h2);
    `CHK(frame_engine_status, 8'h00)
    nd.pulse(4);
    `CHK(cmd_reg, 4'h0)
    $display("test rx frame done");
  endtask : test_rx_frame

  // Receive header alone, then a sent response; only the first byte may raise the flag.
  task test_slave_tx;
    wcmd(4'h4);
    nd.pulse(0);
    `CHK(frame_engine_status, 8'h08)
    nd.pulse(1);
    `CHK(frame_engine_status, 8'h00)
    `CHK(cmd_reg, 4'h0)
    wcmd(4'h2);
    nd.pulse(2);
    `CHK(frame_engine_status, 8'h05)
    nd.rx_byte(8'h00, 1'b1);
    @(negedge clock);
    nd.rx_byte(8'h00, 1'b0);
    `CHK(frame_engine_status, 8'h05)
    nd.pulse(3);
    `CHK(frame_engine_status, 8'h10)
    `CHK(cmd_reg, 4'h0)
    $display("test slave tx done");
  endtask : test_slave_tx

  // An error in mid-header drops busy, the break fault and the command, with no done bit.
  task test_abort;
    wcmd(4'h1);
    nd.pulse(0);
    nd.levels(1'b1, 1'b0, 1'b1);
    @(negedge clock);
    nd.levels(1'b0, 1'b0, 1'b1);
    `CHK(frame_engine_status, 8'h44)
    nd.pulse(4);
    `CHK(frame_engine_status, 8'h00)
    `CHK(cmd_reg, 4'h0)
    $display("test abort done");
  endtask : test_abort

  // ----------------------------------------------------------------
  // Sequencing and verdict
  // ----------------------------------------------------------------
  task summarize;
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize

  // The tests need well under two thousand cycles, so five thousand means a hang.
  initial begin
    #(20 * 5000);
    errors++;
    summarize();
  end

  initial begin
    repeat (12) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    `CHK({cmd_reg, sync_period_measure, frame_engine_status}, 20'h0_0000)
    test_sync();
    test_tx_header();
    test_rx_frame();
    test_slave_tx();
    test_abort();
    summarize();
  end
endmodule : test_lfs_frame_status
